// File: memory_request_port_tb.sv
// Self-checking bench of the request port driven by the application model
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end

module memory_request_port_tb;
  import mrp_pkg::*;
  import mrp_tb_pkg::*;
  localparam int DW = HALF_DATA_W;
  typedef struct packed {
    mrp_hdr_type   h;
    logic          f;
    logic          l;
    logic [DW-1:0] d;
  } mrp_exp_type;

  logic               clk, reset, offer, accept, first, last;
  logic               lvalid, lready, lfirst, llast, open_ff;
  logic               lvalid2, lfirst2, llast2;
  logic [TAG_W-1:0]   label, lab, tag_nx;
  logic [OPC_W-1:0]   opcode;
  logic [STACK_W-1:0] stack;
  logic [LOC_W-1:0]   loc;
  logic [DW-1:0]      payload, lpay, lpay2;
  mrp_hdr_type        lhdr, lhdr2;
  int                 fail_count, checks_done, n;
  mrp_exp_type        exp_q[$];
  mrp_exp_type        e;
  // Read, posted, bit-write, plain write, then a four-beat write
  mrp_beat_type rows [8] = '{
    '{1'h1, 1'h1, 9'h005, 6'h30, 3'h1, 34'h1_2345_6789, 8'h11},
    '{1'h1, 1'h1, 9'h0aa, 6'h18, 3'h2, 34'h0_0000_00f7, 8'h22},
    '{1'h1, 1'h1, 9'h033, 6'h11, 3'h3, 34'h2_0000_000c, 8'h33},
    '{1'h1, 1'h1, 9'h044, 6'h08, 3'h4, 34'h0_00ab_cdef, 8'h44},
    '{1'h1, 1'h0, 9'h055, 6'h0f, 3'h5, 34'h3_ffff_fff5, 8'h50},
    '{1'h0, 1'h0, 9'h055, 6'h0f, 3'h5, 34'h3_ffff_fff5, 8'h51},
    '{1'h0, 1'h0, 9'h055, 6'h0f, 3'h5, 34'h3_ffff_fff5, 8'h52},
    '{1'h0, 1'h1, 9'h055, 6'h0f, 3'h5, 34'h3_ffff_fff5, 8'h53}};

  mrp_request_port #(.DATA_W(DW)) u_mrp_request_port (
    .clk(clk), .reset(reset), .port_request_offer(offer),
    .port_request_accept(accept), .port_request_label(label),
    .port_request_opcode(opcode), .port_target_stack_id(stack),
    .port_target_location(loc), .port_write_payload(payload),
    .port_packet_first(first), .port_packet_last(last),
    .link_request_valid(lvalid), .link_request_ready(lready),
    .link_request_header(lhdr), .link_request_first(lfirst),
    .link_request_last(llast), .link_request_payload(lpay));

  // Reorder variant at half width; its port setting must fall back to one
  mrp_request_port #(.DATA_W(DW), .PORTS(3), .PORT_INDEX(1),
    .REORDER(1'b1)) u_mrp_request_port_b (
    .clk(clk), .reset(reset), .port_request_offer(offer),
    .port_request_accept(), .port_request_label(label),
    .port_request_opcode(opcode), .port_target_stack_id(stack),
    .port_target_location(loc), .port_write_payload(payload),
    .port_packet_first(first), .port_packet_last(last),
    .link_request_valid(lvalid2), .link_request_ready(lready),
    .link_request_header(lhdr2), .link_request_first(lfirst2),
    .link_request_last(llast2), .link_request_payload(lpay2));

  mrp_app_model #(.DATA_W(DW)) u_mrp_app_model (
    .clk(clk), .reset(reset), .offer(offer), .accept(accept),
    .label(label), .opcode(opcode), .stack(stack), .loc(loc),
    .payload(payload), .first(first), .last(last));

  function automatic mrp_exp_type expect_of(input mrp_beat_type b);
    mrp_exp_type r;
    r.h = {b.label, b.opcode, b.stack, b.loc};
    r.f = b.first;
    r.l = b.last;
    if (b.opcode[5:3] == OPC_POSTED_GRP) r.h.port_request_label = '0;
    if (b.opcode != OPC_BIT_WRITE) r.h.port_target_location[3:0] = 4'h0;
    r.d = (b.opcode[5:3] == OPC_READ_GRP) ? '0 : {(DW/8){b.fill}};
    return r;
  endfunction : expect_of

  task automatic send(input mrp_beat_type b);
    u_mrp_app_model.push(b);
    exp_q.push_back(expect_of(b));
  endtask : send

  task automatic wait_drain;
    n = 0;
    while (exp_q.size() > 0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    `CHK(exp_q.size(), 0)
  endtask : wait_drain

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (reset) begin
      open_ff <= 1'h0;
      tag_nx = '0;
    end else begin
      if (open_ff) `CHK(accept, 1'h1)
      if (offer && accept) open_ff <= !last;
      if (lvalid && lready) begin
        if (exp_q.size() == 0) `CHK(lvalid, 1'h0)
        else begin
          e = exp_q.pop_front();
          `CHK(lhdr, e.h)
          `CHK({lfirst, llast}, {e.f, e.l})
          `CHK(lpay, e.d)
          // Internal labels count up from zero per non-posted request
          if (e.f && e.h.port_request_opcode[5:3] == OPC_POSTED_GRP) begin
            lab = '0;
          end else if (e.f) begin
            lab = tag_nx;
            tag_nx = TAG_W'(tag_nx + 1'b1);
          end
          `CHK(lhdr2.port_request_label, lab)
          `CHK({lvalid2, lfirst2, llast2}, {1'h1, e.f, e.l})
          `CHK(lpay2, e.d)
        end
      end
    end
  end

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #60000;
    fail_count++;
    wrap_up();
  end

  initial begin
    reset = 1'h1;
    lready = 1'h0;
    open_ff = 1'h0;
    fail_count = 0;
    checks_done = 0;
    repeat (2) @(negedge clk);
    `CHK(accept, 1'h0)
    `CHK(lvalid, 1'h0)
    reset = 1'h0;
    lready = 1'h1;
    foreach (rows[i]) send(rows[i]);
    wait_drain();
    // Far side stalls, so the buffer fills and the port must refuse
    lready = 1'h0;
    for (int i = 0; i < 20; i++) begin
      send('{1'h1, 1'h1, TAG_W'(i), 6'h08, 3'h6, 34'h0_0000_0100,
             8'(i)});
    end
    repeat (40) @(negedge clk);
    `CHK(accept, 1'h0)
    `CHK(lvalid, 1'h1)
    lready = 1'h1;
    wait_drain();
    // Mid-run reset empties the port and restarts the internal labels
    reset = 1'h1;
    repeat (2) @(negedge clk);
    `CHK({accept, lvalid}, 2'h0)
    reset = 1'h0;
    @(negedge clk);
    `CHK(accept, 1'h1)
    send(rows[3]);
    wait_drain();
    wrap_up();
  end
endmodule : memory_request_port_tb

// File: mrp_app_model.sv
// Application-side model that offers request beats to the port
`timescale 1ns/1ps

package mrp_tb_pkg;
  import mrp_pkg::*;
  typedef struct packed {
    logic               first;
    logic               last;
    logic [TAG_W-1:0]   label;
    logic [OPC_W-1:0]   opcode;
    logic [STACK_W-1:0] stack;
    logic [LOC_W-1:0]   loc;
    logic [7:0]         fill;
  } mrp_beat_type;
endpackage : mrp_tb_pkg

////////////////////////////////////////////////////////////////////////////
module mrp_app_model
  import mrp_pkg::*;
  import mrp_tb_pkg::*;
#(
  parameter int DATA_W = FULL_DATA_W
) (
  input  wire logic          clk,
  input  wire logic          reset,
  output logic               offer,
  input  wire logic          accept,
  output logic [TAG_W-1:0]   label,
  output logic [OPC_W-1:0]   opcode,
  output logic [STACK_W-1:0] stack,
  output logic [LOC_W-1:0]   loc,
  output logic [DATA_W-1:0]  payload,
  output logic               first,
  output logic               last
);
  mrp_beat_type q[$];
  mrp_beat_type b;
  logic         took_ff;

  task automatic push(input mrp_beat_type nb);
    q.push_back(nb);
  endtask : push

  initial begin
    {offer, label, opcode, stack, loc, payload, first, last} = '0;
    took_ff = 1'h0;
  end

  always @(posedge clk) begin
    took_ff <= offer & accept;
  end

  // Beat held until taken; while no beat is queued, payload and location toggle so stale data shows
  always @(negedge clk) begin
    if (!offer || took_ff) begin
      if (q.size() > 0 && !reset) begin
        b = q.pop_front();
        offer <= 1'h1;
        {first, last} <= {b.first, b.last};
        {label, opcode} <= {b.label, b.opcode};
        {stack, loc} <= {b.stack, b.loc};
        payload <= {(DATA_W/8){b.fill}};
      end else begin
        offer <= 1'h0;
        {first, last} <= 2'h0;
        payload <= ~payload;
        loc <= ~loc;
      end
    end
  end
endmodule : mrp_app_model

// File: mrp_pkg.sv
// Constants, header layout and opcode helpers of the request port
package mrp_pkg;

  localparam int TAG_W             = 9;
  localparam int OPC_W             = 6;
  localparam int STACK_W           = 3;
  localparam int LOC_W             = 34;
  localparam int FULL_DATA_W       = 512;
  localparam int HALF_DATA_W       = 256;
  localparam int MAX_PAYLOAD_BYTES = 128;
  localparam int FIFO_DEPTH        = 16;
  localparam int LOC_IGNORED_LSBS  = 4;
  localparam int BEAT_W            = 3;

  localparam logic [OPC_W-1:0]   OPC_BIT_WRITE = 6'h11;
  localparam logic [2:0]         OPC_POSTED_GRP = 3'h3;
  localparam logic [2:0]         OPC_READ_GRP  = 3'h6;
  localparam logic [TAG_W-1:0]   TAG_RST       = 9'h000;
  localparam logic               ACCEPT_RST    = 1'b0;
  localparam logic [BEAT_W-1:0]  BEATS_RST     = 3'h0;

  typedef struct packed {
    logic [TAG_W-1:0]   port_request_label;
    logic [OPC_W-1:0]   port_request_opcode;
    logic [STACK_W-1:0] port_target_stack_id;
    logic [LOC_W-1:0]   port_target_location;
  } mrp_hdr_type;

  typedef enum logic {
    MRP_IDLE   = 1'b0,
    MRP_IN_PKT = 1'b1
  } mrp_fsm_type;

  // Tag window of one port; upper bound is inclusive
  function automatic logic [TAG_W-1:0] mrp_tag_lo(input int ports,
                                                 input int idx);
    case (ports)
      2:       mrp_tag_lo = (idx == 1) ? 9'h100 : 9'h000;
      3:       mrp_tag_lo = (idx == 2) ? 9'h160 :
                            (idx == 1) ? 9'h0b0 : 9'h000;
      4:       mrp_tag_lo = TAG_W'(idx * 128);
      default: mrp_tag_lo = 9'h000;
    endcase
  endfunction : mrp_tag_lo

  function automatic logic [TAG_W-1:0] mrp_tag_hi(input int ports,
                                                 input int idx);
    case (ports)
      2:       mrp_tag_hi = (idx == 1) ? 9'h1ff : 9'h0ff;
      3:       mrp_tag_hi = (idx == 2) ? 9'h1ff :
                            (idx == 1) ? 9'h15f : 9'h0af;
      4:       mrp_tag_hi = TAG_W'(idx * 128 + 127);
      default: mrp_tag_hi = 9'h1ff;
    endcase
  endfunction : mrp_tag_hi

  function automatic logic mrp_is_posted(input logic [OPC_W-1:0] op);
    mrp_is_posted = (op[5:3] == OPC_POSTED_GRP);
  endfunction : mrp_is_posted

  function automatic logic mrp_is_read(input logic [OPC_W-1:0] op);
    mrp_is_read = (op[5:3] == OPC_READ_GRP);
  endfunction : mrp_is_read

endpackage : mrp_pkg

// File: mrp_request_port.sv
// Request port: header capture, tag handling and buffered hand-off
// Notes on behaviour
// R1 - A beat is taken only when offer and accept are both high.
// R2 - Application keeps offer high over every beat of a write.
// R3 - Application may stream requests back to back with offer held.
// R4 - Application drives a fresh label for each back-to-back request.
// R5 - The nine-bit label travels with the request for its response.
// R6 - With reorder option on, label input ignored; tags made internally.
// R7 - Label is ignored for posted requests.
// R8 - Application never has two outstanding non-posted requests same label.
// R9 - Two ports: labels 0-255 and 256-511.
// R10 - Three ports: labels 0-175, 176-351, 352-511.
// R11 - Four ports: labels 0-127, 128-255, 256-383, 384-511.
// R12 - Application holds label, opcode, stack, location over write beats.
// R13 - Each request carries a six-bit opcode.
// R14 - Each request carries a three-bit stack identifier.
// R15 - 34-bit location; low four bits zero except bit-write.
// R16 - Payload bus is 512 bits full width, 256 bits half width.
// R17 - Payload lowest bytes go first, ascending on later beats.
// R18 - Leftover bytes sit in the low bytes of the final beat.
// R19 - Payload contents are disregarded for read requests.
// R20 - First marker is raised on the first beat of every request.
// R21 - Last marker on the last beat; single beat carries both.
// R22 - Accept may drop to stall, but never between write beats.
// R23 - Payload at most 128 bytes: two or four beats.
// R24 - Several ports only at full width; half width has one.
// R25 - Header fields are captured from the beat marked first.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module mrp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16,
  parameter int LW    = $clog2(DEPTH + 1)
) (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data,
  output logic [LW-1:0]      level
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [LW-1:0]           level;
    logic                    in_ready;
    logic                    out_valid;
  } mrp_fifo_state_type;

  mrp_fifo_state_type state_ff;
  mrp_fifo_state_type nxt_state;
  logic [LW-1:0]      lvl;

  // Shift-down storage keeps the head in a fixed flop, so outputs are
  // registered at the cost of moving every entry on a pop
  always_comb begin
    nxt_state = state_ff;
    lvl       = state_ff.level;
    if (state_ff.out_valid && out_ready) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        nxt_state.mem[i] = state_ff.mem[i+1];
      end
      lvl = LW'(state_ff.level - 1'b1);
    end
    if (in_valid && state_ff.in_ready) begin
      nxt_state.mem[lvl] = in_data;
      lvl = LW'(lvl + 1'b1);
    end
    nxt_state.level     = lvl;
    nxt_state.in_ready  = (lvl < LW'(DEPTH));
    nxt_state.out_valid = (lvl != '0);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign in_ready  = state_ff.in_ready;
  assign out_valid = state_ff.out_valid;
  assign out_data  = state_ff.mem[0];
  assign level     = state_ff.level;

endmodule : mrp_fifo

////////////////////////////////////////////////////////////////////////////
module mrp_request_port
  import mrp_pkg::*;
#(
  parameter int DATA_W     = FULL_DATA_W,
  parameter int PORTS      = 1,
  parameter int PORT_INDEX = 0,
  parameter bit REORDER    = 1'b0,
  parameter int DEPTH      = FIFO_DEPTH
) (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               port_request_offer,
  output logic                    port_request_accept,
  input  wire logic [TAG_W-1:0]   port_request_label,
  input  wire logic [OPC_W-1:0]   port_request_opcode,
  input  wire logic [STACK_W-1:0] port_target_stack_id,
  input  wire logic [LOC_W-1:0]   port_target_location,
  input  wire logic [DATA_W-1:0]  port_write_payload,
  input  wire logic               port_packet_first,
  input  wire logic               port_packet_last,
  output logic                    link_request_valid,
  input  wire logic               link_request_ready,
  output mrp_hdr_type             link_request_header,
  output logic                    link_request_first,
  output logic                    link_request_last,
  output logic [DATA_W-1:0]       link_request_payload
);
  // Half width forces a single port
  localparam int EFF_PORTS = (DATA_W == HALF_DATA_W) ? 1 : PORTS; // see R24
  localparam int MAX_BEATS = (MAX_PAYLOAD_BYTES * 8) / DATA_W;     // see R23
  localparam int WORD_W    = $bits(mrp_hdr_type) + 2 + DATA_W;
  localparam int LW        = $clog2(DEPTH + 1);
  localparam logic [TAG_W-1:0] TAG_LO = mrp_tag_lo(EFF_PORTS, PORT_INDEX);
  localparam logic [TAG_W-1:0] TAG_HI = mrp_tag_hi(EFF_PORTS, PORT_INDEX);

  typedef struct packed {
    mrp_fsm_type       fsm;
    logic              accept;
    logic [BEAT_W-1:0] beats;
    mrp_hdr_type       hdr;
    logic [TAG_W-1:0]  tag_ctr;
  } mrp_state_type;

  mrp_state_type       state_ff;
  mrp_state_type       nxt_state;
  mrp_hdr_type         built;
  mrp_hdr_type         hdr_now;
  logic [DATA_W-1:0]   payload_now;
  logic [WORD_W-1:0]   push_word;
  logic [WORD_W-1:0]   head_word;
  logic                take;
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  logic [LW-1:0]       fifo_level;
  logic [LW:0]         lvl_next;

  // Every check below runs on the core clock and rests in reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state = state_ff;
    take = port_request_offer && state_ff.accept && fifo_in_ready; // see R1

    built.port_request_opcode  = port_request_opcode;              // see R13
    built.port_target_stack_id = port_target_stack_id;             // see R14
    if (REORDER) begin
      built.port_request_label = state_ff.tag_ctr;                 // see R6
    end else begin
      built.port_request_label = port_request_label;               // see R5
    end
    if (mrp_is_posted(port_request_opcode)) begin
      built.port_request_label = TAG_RST;                          // see R7
    end
    built.port_target_location = port_target_location;
    if (port_request_opcode != OPC_BIT_WRITE) begin
      built.port_target_location[LOC_IGNORED_LSBS-1:0] = '0;       // see R15
    end

    // Later beats reuse the captured header even if inputs wander
    hdr_now = port_packet_first ? built : state_ff.hdr;            // see R25
    payload_now = port_write_payload;
    if (mrp_is_read(hdr_now.port_request_opcode)) begin
      payload_now = '0;                                            // see R19
    end
    push_word = {hdr_now, port_packet_first, port_packet_last, payload_now};

    if (take) begin
      nxt_state.hdr = hdr_now;
      nxt_state.beats = port_packet_first ? BEAT_W'(1)
                                          : BEAT_W'(state_ff.beats + 1'b1);
      case (state_ff.fsm)
        MRP_IDLE: begin
          if (port_packet_first && !port_packet_last) begin
            nxt_state.fsm = MRP_IN_PKT;
          end
        end
        MRP_IN_PKT: begin
          if (port_packet_last) begin
            nxt_state.fsm = MRP_IDLE;
          end
        end
        default: begin
          nxt_state.fsm = MRP_IDLE;
        end
      endcase
      if (REORDER && port_packet_first &&
          !mrp_is_posted(port_request_opcode)) begin
        nxt_state.tag_ctr = (state_ff.tag_ctr == TAG_HI) ? TAG_LO
                          : TAG_W'(state_ff.tag_ctr + 1'b1);
      end
    end

    // Room for a whole write is reserved before its first beat, so
    // accept stays high until the last beat; costs idle slots when full
    lvl_next = (LW+1)'(fifo_level) + (LW+1)'(take)
             - (LW+1)'(fifo_out_valid && link_request_ready);
    nxt_state.accept = (nxt_state.fsm == MRP_IN_PKT) ||
                       ((LW+1)'(DEPTH) - lvl_next >= (LW+1)'(MAX_BEATS)); // see R22
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff         <= '0;
      state_ff.fsm     <= MRP_IDLE;
      state_ff.accept  <= ACCEPT_RST;
      state_ff.beats   <= BEATS_RST;
      state_ff.tag_ctr <= TAG_LO;
    end else begin
      state_ff <= nxt_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  mrp_fifo #(
    .W     (WORD_W),
    .DEPTH (DEPTH),
    .LW    (LW)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (take),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word),
    .out_valid (fifo_out_valid),
    .out_ready (link_request_ready),
    .out_data  (head_word),
    .level     (fifo_level)
  );

  assign port_request_accept  = state_ff.accept;
  assign link_request_valid   = fifo_out_valid;
  assign link_request_header  = head_word[WORD_W-1 -: $bits(mrp_hdr_type)];
  assign link_request_first   = head_word[DATA_W+1];
  assign link_request_last    = head_word[DATA_W];
  assign link_request_payload = head_word[DATA_W-1:0];              // see R16

  //////////////////////////////////////////////////////////////////////////
  a_accept_mid_write: assert property // see R22
    (state_ff.fsm == MRP_IN_PKT |-> port_request_accept)
    else $error("accept dropped inside a write");

  a_take_needs_both: assert property // see R1
    (!(port_request_offer && port_request_accept) && !link_request_ready
     |=> fifo_level == $past(fifo_level))
    else $error("beat taken without offer and accept");

  a_posted_label_zero: assert property // see R7
    (link_request_valid &&
     mrp_is_posted(link_request_header.port_request_opcode)
     |-> link_request_header.port_request_label == TAG_RST)
    else $error("posted request carries a label");

  a_read_no_payload: assert property // see R19
    (link_request_valid &&
     mrp_is_read(link_request_header.port_request_opcode)
     |-> link_request_payload == '0)
    else $error("read request carries payload");

  a_location_low_zero: assert property // see R15
    (link_request_valid &&
     link_request_header.port_request_opcode != OPC_BIT_WRITE
     |-> link_request_header.port_target_location[3:0] == 4'h0)
    else $error("location low bits not cleared");

  a_reserve_room: assert property // see R23
    (port_request_accept && state_ff.fsm == MRP_IDLE
     |-> DEPTH - fifo_level >= MAX_BEATS)
    else $error("accept high without room for a whole write");

  a_refuse_when_full: assert property // see R22
    (state_ff.fsm == MRP_IDLE && DEPTH - fifo_level < MAX_BEATS
     |-> !port_request_accept)
    else $error("accept high with too little room");

  a_beats_bounded: assert property // see R23
    (state_ff.beats <= BEAT_W'(MAX_BEATS))
    else $error("write ran past the beat limit");

  a_label_passes: assert property // see R5
    (!REORDER && take && port_packet_first &&
     !mrp_is_posted(port_request_opcode)
     |=> state_ff.hdr.port_request_label == $past(port_request_label))
    else $error("label not carried through");

  a_header_held: assert property // see R25
    (take && !port_packet_first ##0 $past(take)
     |=> state_ff.hdr == $past(state_ff.hdr))
    else $error("header changed on a later beat");

  a_tag_in_window: assert property // see R6
    (REORDER |-> state_ff.tag_ctr >= TAG_LO && state_ff.tag_ctr <= TAG_HI)
    else $error("internal tag left the port window");

endmodule : mrp_request_port
